// file: src/mdr_pkg.sv
// constants and types shared by the monitor data register map
// Notes on behaviour
// - two ideality registers at 21h and 22h
// - serial mode: value low byte, high zero
// - two-wire mode: value high byte, low ones
// - adjust byte is signed, zero means nominal
// - sixteen read-only 12-bit results, 23h-32h
// - result n holds channel n, none shared
// - twelve output codes 33h-3Eh feed latches
// - twelve clear codes 3Fh-4Ah load on clear
// - port bit one releases, zero drives low
// - port read returns sampled pin levels
// - port register 4Bh resets 00FFh, top zero
// - remote one enabled ignores port bits 4,5
// - remote two enabled ignores port bits 6,7
// - configuration register 4Ch, reset 2000h
// - remote sensor enables, default enabled
package mdr_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 16;
  localparam int          CODE_W          = 12;
  localparam int          NUM_RESULT      = 16;
  localparam int          NUM_OUT         = 12;
  localparam int          NUM_PIN         = 8;
  localparam logic [6:0]  ADDR_TEMP_CFG   = 7'h0A;
  localparam logic [6:0]  ADDR_IDEAL_A    = 7'h21;
  localparam logic [6:0]  ADDR_IDEAL_B    = 7'h22;
  localparam logic [6:0]  ADDR_RESULT_LO  = 7'h23;
  localparam logic [6:0]  ADDR_RESULT_HI  = 7'h32;
  localparam logic [6:0]  ADDR_OUT_LO     = 7'h33;
  localparam logic [6:0]  ADDR_OUT_HI     = 7'h3E;
  localparam logic [6:0]  ADDR_CLR_LO     = 7'h3F;
  localparam logic [6:0]  ADDR_CLR_HI     = 7'h4A;
  localparam logic [6:0]  ADDR_PORT       = 7'h4B;
  localparam logic [6:0]  ADDR_CFG0       = 7'h4C;
  localparam logic [7:0]  IDEAL_RESET     = 8'h00;
  localparam logic [7:0]  FILL_ONES       = 8'hFF;
  localparam logic [7:0]  PORT_RESET      = 8'hFF;
  localparam logic [15:0] CFG0_RESET      = 16'h2000;
  localparam logic [15:0] CFG0_WR_MASK    = 16'h3EFF;
  localparam int          SPI_R2EN_BIT    = 5;
  localparam int          SPI_R1EN_BIT    = 4;
  localparam int          I2C_R2EN_BIT    = 13;
  localparam int          I2C_R1EN_BIT    = 12;
  localparam int          R1_PIN_LO       = 4;
  localparam int          R2_PIN_LO       = 6;
  localparam logic [11:0] CODE_RESET      = 12'h000;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } mdr_req_s;
endpackage : mdr_pkg

// file: src/mdr_regmap.sv
// register map: ideality, results, output codes, port pins, configuration
`timescale 1ns/100ps
module mdr_regmap #(
  parameter int NUM_RESULT = mdr_pkg::NUM_RESULT,
  parameter int NUM_OUT    = mdr_pkg::NUM_OUT,
  parameter int CODE_W     = mdr_pkg::CODE_W,
  parameter int NUM_PIN    = mdr_pkg::NUM_PIN
) (
  input  wire logic                          mclk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          ce_in,
  input  wire logic                          i2c_mode_in,
  input  wire mdr_pkg::mdr_req_s             req_in,
  output logic [15:0]                        rdata_out,
  output logic                               rvalid_out,
  input  wire logic [NUM_RESULT-1:0]         result_load_in,
  input  wire logic [NUM_RESULT*CODE_W-1:0]  result_code_in,
  input  wire logic [NUM_OUT-1:0]            latch_load_in,
  input  wire logic [NUM_OUT-1:0]            latch_clear_in,
  output logic [NUM_OUT*CODE_W-1:0]          latch_code_out,
  output logic [7:0]                         ideality_adjust_a_out,
  output logic [7:0]                         ideality_adjust_b_out,
  output logic                               remote_one_enable_out,
  output logic                               remote_two_enable_out,
  output logic [15:0]                        device_config_out,
  input  wire logic [NUM_PIN-1:0]            pin_in,
  output logic [NUM_PIN-1:0]                 pin_out,
  output logic [NUM_PIN-1:0]                 pin_oe_out
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]         ideal_a_reg;
  logic [7:0]         ideal_b_reg;
  logic               r1_en_reg;
  logic               r2_en_reg;
  logic [15:0]        cfg0_reg;
  logic [NUM_PIN-1:0] port_reg;
  logic [NUM_PIN-1:0] pin_sample_reg;
  logic [NUM_PIN-1:0] oe_reg;
  logic [15:0]        rdata_reg;
  logic               rvalid_reg;
  logic [CODE_W-1:0]  result_mem [NUM_RESULT];
  logic [CODE_W-1:0]  out_mem    [NUM_OUT];
  logic [CODE_W-1:0]  clr_mem    [NUM_OUT];
  logic [CODE_W-1:0]  latch_mem  [NUM_OUT];

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire        wr_go      = ce_in & req_in.wr;
  wire [6:0]  a          = req_in.addr;
  wire        hit_tcfg   = (a == mdr_pkg::ADDR_TEMP_CFG);
  wire        hit_ia     = (a == mdr_pkg::ADDR_IDEAL_A);
  wire        hit_ib     = (a == mdr_pkg::ADDR_IDEAL_B);
  wire        hit_res    = (a >= mdr_pkg::ADDR_RESULT_LO) && (a <= mdr_pkg::ADDR_RESULT_HI);
  wire        hit_out    = (a >= mdr_pkg::ADDR_OUT_LO) && (a <= mdr_pkg::ADDR_OUT_HI);
  wire        hit_clr    = (a >= mdr_pkg::ADDR_CLR_LO) && (a <= mdr_pkg::ADDR_CLR_HI);
  wire        hit_port   = (a == mdr_pkg::ADDR_PORT);
  wire        hit_cfg0   = (a == mdr_pkg::ADDR_CFG0);
  wire [6:0]  res_off    = a - mdr_pkg::ADDR_RESULT_LO;
  wire [6:0]  out_off    = a - mdr_pkg::ADDR_OUT_LO;
  wire [6:0]  clr_off    = a - mdr_pkg::ADDR_CLR_LO;
  wire [3:0]  res_idx    = res_off[3:0];
  wire [3:0]  out_idx    = out_off[3:0];
  wire [3:0]  clr_idx    = clr_off[3:0];
  // adjust byte lane depends on interface mode; the other lane is dropped
  wire [7:0]  adj_wr     = i2c_mode_in ? req_in.wdata[15:8]
                                       : req_in.wdata[7:0];
  wire        wr_r1en    = i2c_mode_in ? req_in.wdata[mdr_pkg::I2C_R1EN_BIT]
                                       : req_in.wdata[mdr_pkg::SPI_R1EN_BIT];
  wire        wr_r2en    = i2c_mode_in ? req_in.wdata[mdr_pkg::I2C_R2EN_BIT]
                                       : req_in.wdata[mdr_pkg::SPI_R2EN_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  function automatic logic [15:0] ideal_view(input logic [7:0] v, input logic i2c);
    ideal_view = i2c ? {v, mdr_pkg::FILL_ONES} : {8'h00, v};
  endfunction : ideal_view

  logic [15:0] tcfg_view;
  always_comb begin
    tcfg_view = 16'h0000;
    if (i2c_mode_in) begin
      tcfg_view[7:0]                       = mdr_pkg::FILL_ONES;
      tcfg_view[mdr_pkg::I2C_R1EN_BIT]     = r1_en_reg;
      tcfg_view[mdr_pkg::I2C_R2EN_BIT]     = r2_en_reg;
    end else begin
      tcfg_view[mdr_pkg::SPI_R1EN_BIT]     = r1_en_reg;
      tcfg_view[mdr_pkg::SPI_R2EN_BIT]     = r2_en_reg;
    end
  end

  wire [15:0] rd_mux =
    hit_tcfg ? tcfg_view :
    hit_ia   ? ideal_view(ideal_a_reg, i2c_mode_in) :
    hit_ib   ? ideal_view(ideal_b_reg, i2c_mode_in) :
    hit_res  ? {4'h0, result_mem[res_idx]} :
    hit_out  ? {4'h0, out_mem[out_idx]} :
    hit_clr  ? {4'h0, clr_mem[clr_idx]} :
    hit_port ? {8'h00, pin_sample_reg} :
    hit_cfg0 ? cfg0_reg :
               16'h0000;                            // unmapped reads as zero

  ////////////////////////////////////////////////////////////////////////////////
  // scalar registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ideal_a_reg <= mdr_pkg::IDEAL_RESET;
      ideal_b_reg <= mdr_pkg::IDEAL_RESET;
      r1_en_reg   <= 1'b1;
      r2_en_reg   <= 1'b1;
      cfg0_reg    <= mdr_pkg::CFG0_RESET;
      port_reg    <= mdr_pkg::PORT_RESET;
    end else if (wr_go) begin
      if (hit_ia)   ideal_a_reg <= adj_wr;
      if (hit_ib)   ideal_b_reg <= adj_wr;
      if (hit_tcfg) begin
        r1_en_reg <= wr_r1en;
        r2_en_reg <= wr_r2en;
      end
      if (hit_cfg0) cfg0_reg <= req_in.wdata & mdr_pkg::CFG0_WR_MASK;
      if (hit_port) port_reg <= req_in.wdata[NUM_PIN-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (ce_in) begin
      rvalid_reg <= req_in.rd;
      if (req_in.rd) rdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port pins: open drain, only ever pulled low
  genvar p;
  generate
    for (p = 0; p < NUM_PIN; p++) begin : g_pin
      // sensor-owned pins stay released whatever the port bit says
      wire in_r1 = (p >= mdr_pkg::R1_PIN_LO) && (p < mdr_pkg::R1_PIN_LO + 2);
      wire in_r2 = (p >= mdr_pkg::R2_PIN_LO) && (p < mdr_pkg::R2_PIN_LO + 2);
      wire owned = (in_r1 & r1_en_reg) | (in_r2 & r2_en_reg);
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          oe_reg[p]         <= 1'b0;
          pin_sample_reg[p] <= 1'b1;
        end else if (ce_in) begin
          oe_reg[p]         <= ~port_reg[p] & ~owned;
          pin_sample_reg[p] <= pin_in[p];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // converter results, written only by the converter side
  genvar r;
  generate
    for (r = 0; r < NUM_RESULT; r++) begin : g_res
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          result_mem[r] <= mdr_pkg::CODE_RESET;
        end else if (ce_in && result_load_in[r]) begin
          result_mem[r] <= result_code_in[r*CODE_W +: CODE_W];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // output channels: data, clear value and latch
  genvar c;
  generate
    for (c = 0; c < NUM_OUT; c++) begin : g_out
      always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
          out_mem[c]   <= mdr_pkg::CODE_RESET;
          clr_mem[c]   <= mdr_pkg::CODE_RESET;
          latch_mem[c] <= mdr_pkg::CODE_RESET;
        end else if (ce_in) begin
          if (req_in.wr && hit_out && out_idx == c) out_mem[c] <= req_in.wdata[CODE_W-1:0];
          if (req_in.wr && hit_clr && clr_idx == c) clr_mem[c] <= req_in.wdata[CODE_W-1:0];
          // clear outranks a load in the same cycle
          if (latch_clear_in[c])     latch_mem[c] <= clr_mem[c];
          else if (latch_load_in[c]) latch_mem[c] <= out_mem[c];
        end
      end
      assign latch_code_out[c*CODE_W +: CODE_W] = latch_mem[c];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  assign rdata_out             = rdata_reg;
  assign rvalid_out            = rvalid_reg;
  assign ideality_adjust_a_out = ideal_a_reg;
  assign ideality_adjust_b_out = ideal_b_reg;
  assign remote_one_enable_out = r1_en_reg;
  assign remote_two_enable_out = r2_en_reg;
  assign device_config_out     = cfg0_reg;
  assign pin_out               = {NUM_PIN{1'b0}};
  assign pin_oe_out            = oe_reg;
endmodule : mdr_regmap

// file: testbench/mdr_pin_model.sv
// open-drain port pins with external pull-ups
`timescale 1ns/100ps
module mdr_pin_model #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] drive_in,
  input  wire logic [N-1:0] oe_in,
  output logic      [N-1:0] level_out
);
  // released pins float up, never hold the last driven value
  assign level_out = (oe_in & drive_in) | ~oe_in;
endmodule : mdr_pin_model

// file: testbench/mdr_regmap_monitor.sv
// concurrent checks on the register map ports
`timescale 1ns/100ps
module mdr_regmap_monitor #(
  parameter int NUM_PIN = 8
) (
  input  wire logic               mclk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               ce_in,
  input  wire logic               i2c_mode_in,
  input  wire mdr_pkg::mdr_req_s  req_in,
  input  wire logic [15:0]        rdata_out,
  input  wire logic               rvalid_out,
  input  wire logic [7:0]         ideality_adjust_a_out,
  input  wire logic               remote_one_enable_out,
  input  wire logic               remote_two_enable_out,
  input  wire logic [15:0]        device_config_out,
  input  wire logic [NUM_PIN-1:0] pin_out,
  input  wire logic [NUM_PIN-1:0] pin_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////
  wire       rd_go = ce_in && req_in.rd;
  wire       rd_id = rd_go && (req_in.addr == 7'h21 || req_in.addr == 7'h22);
  wire       wr_a  = ce_in && req_in.wr && req_in.addr == 7'h21;
  // write lane follows the bus layout in force at the taking edge
  wire [7:0] lane  = i2c_mode_in ? req_in.wdata[15:8] : req_in.wdata[7:0];
  ////////////////////////////////////////////////////////////
  a_valid_after_read: assert property (rd_go |=> rvalid_out)
    else $error("read not answered");
  a_valid_no_read: assert property (!rd_go |=> !rvalid_out)
    else $error("answer without read");
  a_result_top_zero: assert property (rd_go && req_in.addr inside {[7'h23:7'h32]}
    |=> rdata_out[15:12] == 4'h0) else $error("result top bits set");
  a_port_top_zero: assert property (rd_go && req_in.addr == 7'h4B
    |=> rdata_out[15:8] == 8'h00) else $error("port top bits set");
  a_ideal_spi_view: assert property (
    rd_id && !i2c_mode_in |=> rdata_out[15:8] == 8'h00)
    else $error("serial ideality high byte set");
  a_ideal_i2c_view: assert property (rd_id && i2c_mode_in |=> rdata_out[7:0] == 8'hFF)
    else $error("two-wire ideality low byte not ones");
  a_ideal_lane_write: assert property (wr_a |=> ideality_adjust_a_out == $past(lane))
    else $error("ideality byte lane wrong");
  a_pin_drive_low: assert property (pin_out == '0)
    else $error("port drives high");
  a_remote_one_pins: assert property (
    remote_one_enable_out && $past(remote_one_enable_out)
    |-> pin_oe_out[5:4] == 2'b00) else $error("pins 4 5 driven while remote one on");
  a_remote_two_pins: assert property (
    remote_two_enable_out && $past(remote_two_enable_out)
    |-> pin_oe_out[7:6] == 2'b00) else $error("pins 6 7 driven while remote two on");
  a_cfg_fixed_zero: assert property (
    device_config_out[15:14] == 2'b00 && !device_config_out[8])
    else $error("fixed config bits set");
endmodule : mdr_regmap_monitor

// file: testbench/tb.sv
// self-checking bench for the monitor data register map
`timescale 1ns/100ps
module tb;
  logic              mclk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              ce = 1'b1;
  logic              i2c = 1'b0;
  mdr_pkg::mdr_req_s req = '0;
  logic [15:0]       rl = '0;
  logic [191:0]      rc = '0;
  logic [11:0]       ll = '0;
  logic [11:0]       lc = '0;
  logic [15:0]       rdata, cfg, d;
  logic              rvalid, r1, r2;
  logic [143:0]      lcode;
  logic [7:0]        ia, ib, po, poe, pin;
  logic [7:0]        v[4];
  logic [15:0]       expq[$];
  logic [11:0]       codes[24];
  logic [31:0]       seed = 32'h0000_19AF;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  ////////////////////////////////////////////////////////////
  mdr_regmap u_mdr_regmap (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
    .i2c_mode_in(i2c), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
    .result_load_in(rl), .result_code_in(rc), .latch_load_in(ll), .latch_clear_in(lc),
    .latch_code_out(lcode), .ideality_adjust_a_out(ia), .ideality_adjust_b_out(ib),
    .remote_one_enable_out(r1), .remote_two_enable_out(r2), .device_config_out(cfg),
    .pin_in(pin), .pin_out(po), .pin_oe_out(poe));
  mdr_pin_model u_mdr_pin_model (.drive_in(po), .oe_in(poe), .level_out(pin));
  always #5 mclk_in = ~mclk_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input logic w, r, input logic [6:0] a, input logic [15:0] wd, e);
    @(posedge mclk_in);
    req <= '{wr: w, rd: r, addr: a, wdata: wd};
    if (r) expq.push_back(e);
  endtask : op
  task automatic idle(input int n);
    @(posedge mclk_in);
    req <= '0;
    repeat (n) @(posedge mclk_in);
  endtask : idle
  task automatic give_verdict();
    // reads that never got an answer count against the run
    if (expq.size() != 0) chk("pending reads", 16'h0000, 16'(expq.size()));
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (rvalid === 1'b1) begin
      if (expq.size() > 0) chk("rdata", expq.pop_front(), rdata);
      else chk("rvalid", 16'h0000, 16'h0001);
    end
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    op(0, 1, 7'h21, 0, 16'h0000);
    op(0, 1, 7'h4C, 0, 16'h2000);
    for (int i = 0; i < 24; i++) op(0, 1, 7'(8'h33 + i), 0, 16'h0000);
    v = '{8'h7F, 8'h80, 8'h00, 8'(rnd())};
    for (int i = 0; i < 4; i++) begin
      op(1, 0, 7'h21, {~v[i], v[i]}, 0);
      op(0, 1, 7'h21, 0, {8'h00, v[i]});
    end
    idle(1);
    i2c <= 1'b1;
    op(0, 1, 7'h21, 0, {v[3], 8'hFF});
    op(0, 1, 7'h0A, 0, 16'h30FF);
    op(1, 0, 7'h22, 16'h805A, 0);
    op(0, 1, 7'h22, 0, 16'h80FF);
    idle(1);
    i2c <= 1'b0;
    chk("adjust b", 16'h0080, {8'h00, ib});
    for (int i = 0; i < 16; i++) rc[12*i +: 12] <= 12'(rnd());
    rl <= 16'hFFFF;
    @(posedge mclk_in);
    rl <= '0;
    op(1, 0, 7'h23, 16'hFFFF, 0);
    for (int i = 0; i < 16; i++) op(0, 1, 7'(8'h23 + i), 0, {4'h0, rc[12*i +: 12]});
    for (int i = 0; i < 24; i++) begin
      d = 16'(rnd());
      codes[i] = d[11:0];
      op(1, 0, 7'(8'h33 + i), d, 0);
      op(0, 1, 7'(8'h33 + i), 0, {4'h0, d[11:0]});
    end
    idle(0);
    ll <= '1;
    lc <= 12'h00F;
    @(posedge mclk_in);
    ll <= '0;
    lc <= '0;
    @(posedge mclk_in);
    for (int i = 0; i < 12; i++)
      chk("latch", {4'h0, codes[i < 4 ? 12 + i : i]}, {4'h0, lcode[12*i +: 12]});
    op(1, 0, 7'h33, 16'h0FFF, 0);
    ce <= 1'b0;
    idle(0);
    ce <= 1'b1;
    op(0, 1, 7'h33, 0, {4'h0, codes[0]});
    op(0, 1, 7'h4B, 0, 16'h00FF);
    op(1, 0, 7'h0A, 16'h0000, 0);
    d = 16'(rnd());
    op(1, 0, 7'h4B, d, 0);
    idle(3);
    chk("pin oe", {8'h00, ~d[7:0]}, {8'h00, poe});
    op(0, 1, 7'h4B, 0, {8'h00, d[7:0]});
    op(1, 0, 7'h0A, 16'h0030, 0);
    idle(3);
    chk("pin oe remote", {12'h000, ~d[3:0]}, {8'h00, poe});
    chk("remote enables", 16'h0003, {14'h0000, r1, r2});
    op(0, 1, 7'h0A, 0, 16'h0030);
    op(1, 0, 7'h4C, 16'hE605, 0);
    op(0, 1, 7'h4C, 0, 16'h2605);
    op(1, 0, 7'h7F, 16'hFFFF, 0);
    op(0, 1, 7'h7F, 0, 16'h0000);
    idle(3);
    sys_rst_in <= 1'b1;
    idle(2);
    sys_rst_in <= 1'b0;
    op(0, 1, 7'h4B, 0, 16'h00FF);
    op(0, 1, 7'h3F, 0, 16'h0000);
    idle(4);
    give_verdict();
  end
endmodule : tb
bind mdr_regmap mdr_regmap_monitor #(.NUM_PIN(NUM_PIN)) u_mdr_regmap_monitor (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .i2c_mode_in(i2c_mode_in),
  .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .ideality_adjust_a_out(ideality_adjust_a_out),
  .remote_one_enable_out(remote_one_enable_out), .remote_two_enable_out(remote_two_enable_out),
  .device_config_out(device_config_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out));
